/* logic/ati_controller.sv */
`timescale 1ns/1ps
`include "ati_defines.svh"

module ati_controller
  import ati_pkg::*;
#(
  parameter int GAP_CYCLES  = `ATI_SAMPLE_GAP_CYC,
  parameter int WAKE_CYCLES = `ATI_REF_WAKE_CYC
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        en,
  ati_link_if.host         link,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  ati_host_state_t state_q;
  logic            ack_q;
  logic            go;
  logic            wr_ctrl;
  logic            rd_op_q;
  logic [5:0]      cfg_q;
  logic [6:0]      taddr_q;
  logic            nack_q;
  logic            settled_q;
  logic [11:0]     data_q;

  assign wr_ctrl         = avs_write & (avs_address == `ATI_REG_CTRL);
  // a new command stalls until the engine is idle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign go              = ack_q & wr_ctrl & avs_writedata[`ATI_CTRL_GO_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (en) begin
      ack_q <= (avs_read | avs_write) & ~ack_q & (~wr_ctrl | (state_q == HS_IDLE));
      if (avs_read & ~ack_q) begin
        case (avs_address)
          `ATI_REG_CTRL:   avs_readdata <= {9'h000, taddr_q, 2'h0, cfg_q, 6'h00, rd_op_q, 1'b0};
          `ATI_REG_STATUS: avs_readdata <= {28'h0000000, state_q == HS_GAP, settled_q, nack_q,
                                            state_q != HS_IDLE};
          `ATI_REG_DATA:   avs_readdata <= {20'h00000, data_q};
          default:         avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // bus engine
  // ----------------------------------------
  logic [1:0]  sda_sync_q;
  logic [6:0]  qtr_q;
  logic        tick;
  logic [1:0]  phase_q;
  logic [3:0]  pos_q;
  logic [1:0]  byte_q;
  logic        scl_q;
  logic        sda_q;
  logic [7:0]  rx_q;
  logic [22:0] gap_q;
  logic [7:0]  src;
  logic        out_bit;
  logic        last_byte;
  logic        sda_in;

  assign sda_in    = sda_sync_q[1];
  assign tick      = qtr_q == 7'(`ATI_QTR_CYCLES - 1);
  assign last_byte = rd_op_q ? (byte_q == 2'h2) : (byte_q == 2'h1);
  assign src       = (byte_q == 2'h0) ? {taddr_q, rd_op_q} : {cfg_q, 2'h0};

  always_comb begin
    if (pos_q == 4'h8) begin
      out_bit = (rd_op_q && byte_q != 2'h0) ? (byte_q == 2'h2) : 1'b1;
    end else if (rd_op_q && byte_q != 2'h0) begin
      out_bit = 1'b1;
    end else begin
      out_bit = src[3'(4'h7 - pos_q)];
    end
  end

  assign link.host_scl_o    = 1'b0;
  assign link.host_scl_oe_n = scl_q;
  assign link.host_sda_o    = 1'b0;
  assign link.host_sda_oe_n = sda_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_sync_q <= 2'h3;
      qtr_q      <= 7'h00;
    end else if (en) begin
      sda_sync_q <= {sda_sync_q[0], link.sda};
      qtr_q      <= (tick || state_q == HS_IDLE) ? 7'h00 : qtr_q + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= HS_IDLE;
      phase_q   <= 2'h0;
      pos_q     <= 4'h0;
      byte_q    <= 2'h0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      rx_q      <= 8'h00;
      gap_q     <= 23'h000000;
      rd_op_q   <= 1'b0;
      cfg_q     <= `ATI_CFG_RESET;
      taddr_q   <= `ATI_TGT_ADDR_BASE;
      nack_q    <= 1'b0;
      data_q    <= `ATI_RESULT_RESET;
    end else if (en) begin
      case (state_q)
        HS_IDLE: begin
          if (go) begin
            state_q <= HS_START;
            rd_op_q <= avs_writedata[`ATI_CTRL_RD_BIT];
            cfg_q   <= avs_writedata[`ATI_CTRL_CFG_LSB +: 6];
            taddr_q <= avs_writedata[`ATI_CTRL_ADDR_LSB +: 7];
            nack_q  <= 1'b0;
            phase_q <= 2'h0;
          end
        end
        HS_START: if (tick) begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h1) sda_q <= 1'b0;
          if (phase_q == 2'h2) begin
            scl_q   <= 1'b0;
            state_q <= HS_BIT;
            phase_q <= 2'h0;
            pos_q   <= 4'h0;
            byte_q  <= 2'h0;
          end
        end
        HS_BIT: if (tick) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: sda_q <= out_bit;
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (pos_q == 4'h8 && !(rd_op_q && byte_q != 2'h0) && sda_in) nack_q <= 1'b1;
              if (pos_q != 4'h8) rx_q <= {rx_q[6:0], sda_in};
            end
            default: begin
              scl_q <= 1'b0;
              if (pos_q == 4'h8) begin
                pos_q  <= 4'h0;
                byte_q <= byte_q + 2'h1;
                if (rd_op_q && byte_q == 2'h1) data_q[11:4] <= rx_q;
                if (rd_op_q && byte_q == 2'h2) data_q[3:0] <= rx_q[7:4];
                if (nack_q || last_byte) state_q <= HS_STOP;
              end else begin
                pos_q <= pos_q + 4'h1;
              end
            end
          endcase
        end
        HS_STOP: if (tick) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: sda_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b1;
            default: begin
              state_q <= nack_q ? HS_IDLE : HS_GAP;
              gap_q   <= 23'(GAP_CYCLES);
            end
          endcase
        end
        HS_GAP: begin
          gap_q <= gap_q - 23'h000001;
          if (gap_q <= 23'h000001) state_q <= HS_IDLE;
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // reference wake tracking
  // ----------------------------------------
  logic        asleep_q;
  logic [24:0] wake_q;

  // settled drops on each wake from sleep until the reference has had time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      asleep_q  <= 1'b0;
      wake_q    <= 25'h0000000;
      settled_q <= 1'b1;
    end else if (en) begin
      if (state_q == HS_STOP && tick && phase_q == 2'h3 && !nack_q && !rd_op_q) begin
        asleep_q <= cfg_q[`ATI_CFG_SLP_BIT];
        if (asleep_q && !cfg_q[`ATI_CFG_SLP_BIT]) begin
          wake_q    <= 25'(WAKE_CYCLES);
          settled_q <= 1'b0;
        end
      end else if (wake_q != 25'h0000000) begin
        wake_q <= wake_q - 25'h0000001;
        if (wake_q == 25'h0000001) settled_q <= 1'b1;
      end
    end
  end

endmodule : ati_controller

/* logic/ati_defines.svh */
`ifndef ATI_DEFINES_SVH
`define ATI_DEFINES_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define ATI_CLK_PERIOD_NS   10
`define ATI_CONV_TIME_NS    1800
`define ATI_CONV_CYCLES     (`ATI_CONV_TIME_NS / `ATI_CLK_PERIOD_NS)
`define ATI_QTR_BIT_NS      650
`define ATI_QTR_CYCLES      (`ATI_QTR_BIT_NS / `ATI_CLK_PERIOD_NS)
`define ATI_SAMPLE_RATE_SPS 14000
`define ATI_SAMPLE_GAP_NS   ((1000000000 + `ATI_SAMPLE_RATE_SPS - 1) / `ATI_SAMPLE_RATE_SPS)
`define ATI_SAMPLE_GAP_CYC  ((`ATI_SAMPLE_GAP_NS + `ATI_CLK_PERIOD_NS - 1) / `ATI_CLK_PERIOD_NS)
`define ATI_REF_WAKE_MS     200
`define ATI_REF_WAKE_CYC    (`ATI_REF_WAKE_MS * 1000000 / `ATI_CLK_PERIOD_NS)

// ----------------------------------------
// target address and configuration word
// ----------------------------------------
`define ATI_TGT_ADDR_BASE   7'h08
`define ATI_CFG_RESET       6'h00
`define ATI_CFG_SD_BIT      5
`define ATI_CFG_OS_BIT      4
`define ATI_CFG_S1_BIT      3
`define ATI_CFG_S0_BIT      2
`define ATI_CFG_UNI_BIT     1
`define ATI_CFG_SLP_BIT     0
`define ATI_RESULT_RESET    12'h000

// ----------------------------------------
// controller register map (byte offsets)
// ----------------------------------------
`define ATI_REG_CTRL        4'h0
`define ATI_REG_STATUS      4'h4
`define ATI_REG_DATA        4'h8
`define ATI_CTRL_GO_BIT     0
`define ATI_CTRL_RD_BIT     1
`define ATI_CTRL_CFG_LSB    8
`define ATI_CTRL_ADDR_LSB   16

`endif

/* logic/ati_link_if.sv */
`timescale 1ns/1ps
interface ati_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // wired-and with pull-up: any active driver pulls the line to its value
  assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
  assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);

  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                output host_sda_o, output host_sda_oe_n);
endinterface : ati_link_if

/* logic/ati_pkg.sv */
package ati_pkg;

  typedef enum logic [1:0] {
    ATI_PIN_LOW   = 2'h0,
    ATI_PIN_HIGH  = 2'h1,
    ATI_PIN_FLOAT = 2'h2
  } ati_pin_t;

  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_ADDR = 7'h02,
    DS_AACK = 7'h04,
    DS_WR   = 7'h08,
    DS_WACK = 7'h10,
    DS_RD   = 7'h20,
    DS_RACK = 7'h40
  } ati_dev_state_t;

  typedef enum logic [4:0] {
    HS_IDLE  = 5'h01,
    HS_START = 5'h02,
    HS_BIT   = 5'h04,
    HS_STOP  = 5'h08,
    HS_GAP   = 5'h10
  } ati_host_state_t;

endpackage : ati_pkg

/* logic/ati_target.sv */
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "ati_defines.svh"

// Overview of operation
// - target only, never drives serial clock
// - incoming bits captured on clock rising edges
// - outgoing bits change on clock falling edges
// - read address shifts out latest result
// - write address receives configuration word
// - data line released or pulled low only
// - two tri-level pins select target address
// - controller keeps sample rate at most 14ksps
// - controller flags 200 ms settling after wake, new commands not held
// - bipolar result in two's complement
// - unipolar result in straight binary
// - stop after addressing starts a conversion
// - address not acknowledged while converting
// - twelve result bits MSB first, four zeros
// - six-bit word: mode, sign, channel, polarity, sleep
module ati_target
  import ati_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        en,
  ati_link_if.dev          link,
  input  wire logic [1:0]  addr_select_pin_low,
  input  wire logic [1:0]  addr_select_pin_high,
  input  wire logic [11:0] sample_code,
  output logic             conv_busy,
  output logic             conv_done,
  output logic             single_ended,
  output logic             odd_sign,
  output logic [1:0]       chan_sel,
  output logic             unipolar_select,
  output logic             sleep_select,
  output logic [11:0]      result
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0]     scl_sync_q;
  logic [1:0]     sda_sync_q;
  logic [3:0]     pin_meta_q;
  logic [3:0]     pin_sync_q;
  logic           scl_prev_q;
  logic           sda_prev_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (en) begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      pin_meta_q <= {addr_select_pin_high, addr_select_pin_low};
      pin_sync_q <= pin_meta_q;
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_s      = scl_sync_q[1];
  assign sda_s      = sda_sync_q[1];
  assign scl_rise   = scl_s & ~scl_prev_q;
  assign scl_fall   = ~scl_s & scl_prev_q;
  assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_seen  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------
  // address strap
  // ----------------------------------------
  function automatic logic [6:0] pin_weight(input logic [1:0] code);
    case (code)
      ATI_PIN_LOW:  pin_weight = 7'h00;
      ATI_PIN_HIGH: pin_weight = 7'h02;
      default:      pin_weight = 7'h01;
    endcase
  endfunction : pin_weight

  logic [6:0] own_addr_q;
  logic [1:0] strap_wait_q;

  // strap is taken once, after the synchroniser has filled following reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      own_addr_q   <= `ATI_TGT_ADDR_BASE;
      strap_wait_q <= 2'h0;
    end else if (en && strap_wait_q != 2'h3) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h2) begin
        own_addr_q <= 7'(`ATI_TGT_ADDR_BASE + 7'h03 * pin_weight(pin_sync_q[3:2])
                      + pin_weight(pin_sync_q[1:0]));
      end
    end
  end

  // ----------------------------------------
  // serial target state machine
  // ----------------------------------------
  ati_dev_state_t state_q;
  logic [7:0]     rx_q;
  logic [7:0]     tx_q;
  logic [3:0]     bit_cnt_q;
  logic           rd_q;
  logic           first_wr_q;
  logic           byte2_q;
  logic           mack_q;
  logic           addressed_q;
  logic           sda_oe_n_q;
  logic [5:0]     cfg_q;
  logic           conv_start;

  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = sda_oe_n_q;
  assign conv_start        = stop_seen & addressed_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= DS_IDLE;
      rx_q        <= 8'h00;
      tx_q        <= 8'h00;
      bit_cnt_q   <= 4'h0;
      rd_q        <= 1'b0;
      first_wr_q  <= 1'b0;
      byte2_q     <= 1'b0;
      mack_q      <= 1'b0;
      addressed_q <= 1'b0;
      sda_oe_n_q  <= 1'b1;
      cfg_q       <= `ATI_CFG_RESET;
    end else if (en) begin
      if (start_seen) begin
        state_q    <= DS_ADDR;
        bit_cnt_q  <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end else if (stop_seen) begin
        state_q     <= DS_IDLE;
        sda_oe_n_q  <= 1'b1;
        addressed_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          DS_ADDR, DS_WR: begin
            rx_q      <= {rx_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          DS_RACK: mack_q <= ~sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_q)
          DS_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (rx_q[7:1] == own_addr_q && !conv_busy) begin
                state_q     <= DS_AACK;
                sda_oe_n_q  <= 1'b0;
                rd_q        <= rx_q[0];
                addressed_q <= 1'b1;
              end else begin
                state_q <= DS_IDLE;
              end
            end
          end
          DS_AACK: begin
            if (rd_q) begin
              state_q    <= DS_RD;
              sda_oe_n_q <= result[11];
              tx_q       <= {result[10:4], 1'b0};
              bit_cnt_q  <= 4'h1;
              byte2_q    <= 1'b0;
            end else begin
              state_q    <= DS_WR;
              sda_oe_n_q <= 1'b1;
              first_wr_q <= 1'b1;
            end
          end
          DS_WR: begin
            if (bit_cnt_q == 4'h8) begin
              state_q    <= DS_WACK;
              sda_oe_n_q <= 1'b0;
              bit_cnt_q  <= 4'h0;
              first_wr_q <= 1'b0;
              if (first_wr_q) begin
                cfg_q <= rx_q[7:2];
              end
            end
          end
          DS_WACK: begin
            state_q    <= DS_WR;
            sda_oe_n_q <= 1'b1;
          end
          DS_RD: begin
            if (bit_cnt_q == 4'h8) begin
              state_q    <= DS_RACK;
              sda_oe_n_q <= 1'b1;
            end else begin
              sda_oe_n_q <= tx_q[7];
              tx_q       <= {tx_q[6:0], 1'b0};
              bit_cnt_q  <= bit_cnt_q + 4'h1;
            end
          end
          DS_RACK: begin
            if (mack_q) begin
              // low nibble then four zeros; later bytes read as zero
              state_q    <= DS_RD;
              sda_oe_n_q <= byte2_q ? 1'b0 : result[3];
              tx_q       <= byte2_q ? 8'h00 : {result[2:0], 5'h00};
              bit_cnt_q  <= 4'h1;
              byte2_q    <= 1'b1;
            end else begin
              state_q <= DS_IDLE;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // conversion timebase
  // ----------------------------------------
  logic [7:0]  conv_cnt_q;
  logic [5:0]  act_cfg_q;
  logic [11:0] sample_q;
  logic [11:0] result_q;
  logic        done_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_cnt_q <= 8'h00;
      act_cfg_q  <= `ATI_CFG_RESET;
      sample_q   <= `ATI_RESULT_RESET;
      result_q   <= `ATI_RESULT_RESET;
      done_q     <= 1'b0;
    end else if (en) begin
      done_q <= 1'b0;
      if (conv_start && conv_cnt_q == 8'h00) begin
        conv_cnt_q <= 8'(`ATI_CONV_CYCLES);
        act_cfg_q  <= cfg_q;
        sample_q   <= sample_code;
      end else if (conv_cnt_q != 8'h00) begin
        conv_cnt_q <= conv_cnt_q - 8'h01;
        if (conv_cnt_q == 8'h01) begin
          done_q   <= 1'b1;
          // unipolar keeps straight binary, bipolar flips msb to two's complement
          result_q <= act_cfg_q[`ATI_CFG_UNI_BIT] ? sample_q
                    : {~sample_q[11], sample_q[10:0]};
        end
      end
    end
  end

  assign conv_busy       = conv_cnt_q != 8'h00;
  assign conv_done       = done_q;
  assign result          = result_q;
  assign single_ended    = act_cfg_q[`ATI_CFG_SD_BIT];
  assign odd_sign        = act_cfg_q[`ATI_CFG_OS_BIT];
  assign chan_sel        = {act_cfg_q[`ATI_CFG_S1_BIT], act_cfg_q[`ATI_CFG_S0_BIT]};
  assign unipolar_select = act_cfg_q[`ATI_CFG_UNI_BIT];
  assign sleep_select    = act_cfg_q[`ATI_CFG_SLP_BIT];
endmodule : ati_target

/* sim/ati_link_sva.sv */
`timescale 1ns/1ps
module ati_link_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // cycles since the last serial clock fall
  // ----------------------------------------
  logic [3:0] fall_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fall_q <= 4'hF;
    end else if ($fell(scl)) begin
      fall_q <= 4'h0;
    end else if (fall_q != 4'hF) begin
      fall_q <= fall_q + 4'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_scl_host; !scl |-> !host_scl_oe_n; endproperty
  a_scl_host: assert property (p_scl_host) else $error("scl low without host pull");
  property p_od; !host_scl_o && !host_sda_o && !dev_sda_o; endproperty
  a_od: assert property (p_od) else $error("driver value not low");
  // both may hold the line low around a clock fall; with the clock high the host must not pull while the target pulls
  property p_dev_low; !dev_sda_oe_n && scl |-> !sda && host_sda_oe_n; endproperty
  a_dev_low: assert property (p_dev_low) else $error("target drive clash");
  // target may only move a few cycles after the clock fell
  property p_dev_chg; $changed(dev_sda_oe_n) |-> !scl && fall_q <= 4'h5; endproperty
  a_dev_chg: assert property (p_dev_chg) else $error("target data moved off falling edge");
  property p_dev_hold; $fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8]; endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("target bit too short");
  property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too short");
  property p_cond; scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe_n); endproperty
  a_cond: assert property (p_cond) else $error("start or stop not from host");

  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
  c_dev: cover property ($fell(dev_sda_oe_n));
endmodule : ati_link_sva

/* sim/i2c_target_adc_interface_tb_top.sv */
`timescale 1ns/1ps
`include "ati_defines.svh"
module i2c_target_adc_interface_tb_top;
  import ati_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  pin_lo = 2'h0;
  logic [1:0]  pin_hi = 2'h0;
  logic [11:0] sample_code = 12'h000;
  logic        conv_busy, conv_done, single_ended, odd_sign, unipolar_select, sleep_select;
  logic        tgt_en = 1'b1;
  logic [1:0]  chan_sel;
  logic [11:0] result;
  logic [27:0] wire_bits = 28'h0;
  int          mismatches = 0;
  int          num_checks = 0;

  always #5 clk = ~clk;
  ati_link_if link ();
  ati_target u_ati_target (.clk(clk), .resetn(resetn), .en(tgt_en), .link(link), .addr_select_pin_low(pin_lo),
    .addr_select_pin_high(pin_hi), .sample_code(sample_code), .conv_busy(conv_busy), .conv_done(conv_done),
    .single_ended(single_ended), .odd_sign(odd_sign), .chan_sel(chan_sel), .unipolar_select(unipolar_select),
    .sleep_select(sleep_select), .result(result));
  // short gap and wake counts keep the run brief
  ati_controller #(.GAP_CYCLES(50), .WAKE_CYCLES(100)) u_ati_controller (.clk(clk), .resetn(resetn),
    .en(1'b1), .link(link), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ati_link_sva u_ati_link_sva (.clk(clk), .resetn(resetn), .host_scl_o(link.host_scl_o),
    .host_scl_oe_n(link.host_scl_oe_n), .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl), .sda(link.sda));

  always @(posedge link.scl) wire_bits <= {wire_bits[26:0], link.sda};

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  // go, direction, config word and target address, then poll until idle
  task automatic xfer(input logic rd, input logic [5:0] cfg, input logic [6:0] a, output logic [31:0] st);
    av(1'b1, `ATI_REG_CTRL, {9'h0, a, 2'h0, cfg, 6'h0, rd, 1'b1}, st);
    do begin
      av(1'b0, `ATI_REG_STATUS, 32'h0, st);
    end while (st[0] !== 1'b0);
  endtask : xfer

  // done pulses in the same cycle that busy drops, so it is looked at right there
  task automatic wait_conv();
    while (conv_busy !== 1'b0) begin
      @(posedge clk);
    end
    chk("conv_done", 32'h1, {31'h0, conv_done});
  endtask : wait_conv

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  function automatic logic [31:0] cfg_out();
    return {26'h0, single_ended, odd_sign, chan_sel, unipolar_select, sleep_select};
  endfunction : cfg_out

  function automatic logic [6:0] wt(input logic [1:0] c);
    return (c == 2'h0) ? 7'h00 : (c == 2'h1) ? 7'h02 : 7'h01;
  endfunction : wt

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    av(1'b0, `ATI_REG_STATUS, 32'h0, q);
    chk("status", 32'h0, q & 32'h3);
    av(1'b0, `ATI_REG_DATA, 32'h0, q);
    chk("data", 32'h0, q);
    av(1'b1, 4'hC, 32'hFFFF_FFFF, q);
    av(1'b0, 4'hC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("result", 32'h0, {20'h0, result});
    chk("cfg", 32'h0, cfg_out());
  endtask : t_reset

  task automatic t_conv();
    logic [31:0] st;
    sample_code <= 12'h5A3;
    xfer(1'b0, 6'h2E, 7'h08, st);
    chk("nack", 32'h0, {31'h0, st[1]});
    chk("conv_busy", 32'h1, {31'h0, conv_busy});
    wait_conv();
    chk("cfg", 32'h2E, cfg_out());
    chk("result", 32'h5A3, {20'h0, result});
    sample_code <= 12'h7FF;
    xfer(1'b1, 6'h00, 7'h08, st);
    av(1'b0, `ATI_REG_DATA, 32'h0, st);
    chk("data", 32'h5A3, st);
    chk("wire", {4'h0, 7'h08, 1'b1, 1'b0, 8'h5A, 1'b0, 4'h3, 4'h0, 1'b1, 1'b0}, {4'h0, wire_bits});
    wait_conv();
    chk("result", 32'h7FF, {20'h0, result});
    sample_code <= 12'h123;
    xfer(1'b0, 6'h00, 7'h09, st);
    chk("nack", 32'h1, {31'h0, st[1]});
    repeat (200) @(posedge clk);
    chk("result", 32'h7FF, {20'h0, result});
  endtask : t_conv

  task automatic t_bipolar();
    logic [31:0] st;
    sample_code <= 12'h800;
    xfer(1'b0, 6'h15, 7'h08, st);
    wait_conv();
    chk("cfg", 32'h15, cfg_out());
    chk("result", 32'h000, {20'h0, result});
    sample_code <= 12'h7FF;
    xfer(1'b1, 6'h00, 7'h08, st);
    wait_conv();
    chk("result", 32'hFFF, {20'h0, result});
    chk("cfg", 32'h15, cfg_out());
    xfer(1'b0, 6'h14, 7'h08, st);
    chk("waking", 32'h0, {31'h0, st[2]});
    // a frozen target must keep its conversion pending
    tgt_en <= 1'b0;
    repeat (200) @(posedge clk);
    chk("frozen", 32'h1, {31'h0, conv_busy});
    tgt_en <= 1'b1;
    wait_conv();
    repeat (120) @(posedge clk);
    av(1'b0, `ATI_REG_STATUS, 32'h0, st);
    chk("settled", 32'h1, {31'h0, st[2]});
  endtask : t_bipolar

  // strap is taken only after reset, so each pin pair needs its own reset
  task automatic t_addr();
    logic [31:0] st;
    logic [6:0]  a;
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        pin_hi <= h[1:0];
        pin_lo <= l[1:0];
        do_reset();
        a = `ATI_TGT_ADDR_BASE + 7'h03 * wt(h[1:0]) + wt(l[1:0]);
        xfer(1'b0, 6'h00, a, st);
        chk("nack", 32'h0, {31'h0, st[1]});
        wait_conv();
      end
    end
  endtask : t_addr

  initial begin
    do_reset();
    t_reset();
    t_conv();
    t_bipolar();
    t_addr();
    end_sim();
  end

  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end
endmodule : i2c_target_adc_interface_tb_top
